//--- rtl/sync_serial_irq_regs.vh
/*
 * Register map, field positions and reset values of the serial port
 * interrupt block.
 * Assumes a 32-bit register bus with one aligned word per register.
 */
`ifndef SYNC_SERIAL_IRQ_REGS_VH
`define SYNC_SERIAL_IRQ_REGS_VH

`define ADDR_W 8
`define DATA_W 32
`define FLAG_W 4

// Byte offsets
`define OFF_CLOCK_PRESCALE 8'h00
`define OFF_INTERRUPT_ENABLE 8'h04
`define OFF_RAW_STATUS 8'h08
`define OFF_MASKED_STATUS 8'h0C
`define OFF_INTERRUPT_CLEAR 8'h10
`define OFF_EVENT_STATUS 8'h14
`define OFF_EVENT_MASK 8'h18

// Flag positions, shared by enable, raw, masked and event registers
`define BIT_RX_OVERRUN 0
`define BIT_RX_TIMEOUT 1
`define BIT_RX_LEVEL 2
`define BIT_TX_LEVEL 3

`define PRESCALE_W 8
`define PRESCALE_RESET 8'h00
`define ENABLE_RESET 4'h0
`define RAW_RESET 4'h8
`define TX_LEVEL_RAW_RESET 1'h1
`define STICKY_RESET 2'h0
`define WSTRB_LOW_LANE 0
`define WSTRB_RESET 4'h0
`define EVENT_MASK_RESET 4'h0
`define FLAGS_CLEAR 4'h0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/irq_flag_cell.v
/*
 * Bank of sticky flags: a set pulse raises a flag, a clear pulse drops it.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ns
module irq_flag_cell #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] set,
    input wire [WIDTH-1:0] clear,
    output reg [WIDTH-1:0] flag_r
);

    // Set wins over a clear in the same cycle, so no event is lost
    always @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= RESET_VALUE;
        end else begin
            flag_r <= set | (flag_r & ~clear);
        end
    end

endmodule

//--- rtl/sync_serial_irq_enable.v
/*
 * Interrupt enable, raw and masked status logic of the synchronous serial
 * port, with an AXI4-Lite register slave and a read-to-clear event bank.
 * Assumes the condition inputs come from serial port logic on aclk.
 */
// Operation
// - Enable bit 3 gates the tx level interrupt, set while tx FIFO is low.
// - Enable bit 2 gates the rx level interrupt from the rx FIFO level.
// - Enable bit 1 gates the rx time-out interrupt for data left unread.
// - Enable bit 0 gates the rx overrun interrupt of a full rx FIFO.
// - Timeout and overrun flags hold until a write of 1 to their clear bit.
// - Masked flags sit at the raw bit positions and need their enable set.
`timescale 1ns/1ns
`include "sync_serial_irq_regs.vh"
module sync_serial_irq_enable (
    input wire aclk,
    input wire aresetn,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [`DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [`DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_fifo_low,
    input wire rx_fifo_level,
    input wire rx_timeout_hit,
    input wire rx_overrun_hit,
    output reg [`PRESCALE_W-1:0] clock_prescale_r,
    output reg irq_r,
    output reg event_irq_r
);

    function word_hit;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] offset;
        begin
            word_hit = (addr[`ADDR_W-1:2] == offset[`ADDR_W-1:2]);
        end
    endfunction

    function mapped;
        input [`ADDR_W-1:0] addr;
        begin
            mapped = word_hit(addr, `OFF_CLOCK_PRESCALE) |
                word_hit(addr, `OFF_INTERRUPT_ENABLE) |
                word_hit(addr, `OFF_RAW_STATUS) |
                word_hit(addr, `OFF_MASKED_STATUS) |
                word_hit(addr, `OFF_INTERRUPT_CLEAR) |
                word_hit(addr, `OFF_EVENT_STATUS) |
                word_hit(addr, `OFF_EVENT_MASK);
        end
    endfunction

    reg [`FLAG_W-1:0] interrupt_enable_r;
    reg [`FLAG_W-1:0] event_mask_r;
    reg tx_level_raw_flag_r;
    reg rx_level_raw_flag_r;
    reg [`FLAG_W-1:0] raw_prev_r;
    reg aw_held_r;
    reg w_held_r;
    reg [`ADDR_W-1:0] aw_addr_r;
    reg [`DATA_W-1:0] w_data_r;
    reg [3:0] w_strb_r;
    wire [1:0] sticky_flags;
    wire [`FLAG_W-1:0] event_status;
    wire [`FLAG_W-1:0] raw_flags;
    wire [`FLAG_W-1:0] masked_flags;
    wire [`FLAG_W-1:0] raw_rise;
    wire wr_fire;
    wire rd_fire;
    wire wr_low_byte;
    wire clear_hit;
    wire [1:0] sticky_clear;
    wire [`FLAG_W-1:0] event_clear;
    wire tx_level_masked_flag;
    wire rx_level_masked_flag;
    wire rx_timeout_masked_flag;
    wire rx_overrun_masked_flag;
    reg [`DATA_W-1:0] rd_word;

    assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign wr_low_byte = wr_fire & w_strb_r[`WSTRB_LOW_LANE];

    // Level conditions are sampled every cycle, whatever the enables say
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_level_raw_flag_r <= `TX_LEVEL_RAW_RESET;
            rx_level_raw_flag_r <= 1'b0;
        end else begin
            tx_level_raw_flag_r <= tx_fifo_low;
            rx_level_raw_flag_r <= rx_fifo_level;
        end
    end

    assign clear_hit = wr_low_byte &
        word_hit(aw_addr_r, `OFF_INTERRUPT_CLEAR);
    // Writing 0 to a clear bit leaves its flag alone
    assign sticky_clear = {w_data_r[`BIT_RX_TIMEOUT] & clear_hit,
        w_data_r[`BIT_RX_OVERRUN] & clear_hit};

    irq_flag_cell #(
        .WIDTH(2),
        .RESET_VALUE(`STICKY_RESET)
    ) u_sticky (
        .aclk(aclk),
        .aresetn(aresetn),
        .set({rx_timeout_hit, rx_overrun_hit}),
        .clear(sticky_clear),
        .flag_r(sticky_flags)
    );

    assign raw_flags = {tx_level_raw_flag_r, rx_level_raw_flag_r,
        sticky_flags};

    assign tx_level_masked_flag = raw_flags[`BIT_TX_LEVEL] &
        interrupt_enable_r[`BIT_TX_LEVEL];
    assign rx_level_masked_flag = raw_flags[`BIT_RX_LEVEL] &
        interrupt_enable_r[`BIT_RX_LEVEL];
    assign rx_timeout_masked_flag = raw_flags[`BIT_RX_TIMEOUT] &
        interrupt_enable_r[`BIT_RX_TIMEOUT];
    assign rx_overrun_masked_flag = raw_flags[`BIT_RX_OVERRUN] &
        interrupt_enable_r[`BIT_RX_OVERRUN];
    assign masked_flags = {tx_level_masked_flag, rx_level_masked_flag,
        rx_timeout_masked_flag, rx_overrun_masked_flag};

    // Event bank records each new raw assertion for read-to-clear polling
    always @(posedge aclk) begin
        if (!aresetn) begin
            raw_prev_r <= `RAW_RESET;
        end else begin
            raw_prev_r <= raw_flags;
        end
    end

    assign raw_rise = raw_flags & ~raw_prev_r;
    assign event_clear = (rd_fire & word_hit(s_axi_araddr,
        `OFF_EVENT_STATUS)) ? {`FLAG_W{1'b1}} : `FLAGS_CLEAR;

    irq_flag_cell #(
        .WIDTH(`FLAG_W),
        .RESET_VALUE(`FLAGS_CLEAR)
    ) u_events (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(raw_rise),
        .clear(event_clear),
        .flag_r(event_status)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
            event_irq_r <= 1'b0;
        end else begin
            irq_r <= |masked_flags;
            event_irq_r <= |(event_status & event_mask_r);
        end
    end

    // Software-written registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            clock_prescale_r <= `PRESCALE_RESET;
            interrupt_enable_r <= `ENABLE_RESET;
            event_mask_r <= `EVENT_MASK_RESET;
        end else if (wr_low_byte) begin
            if (word_hit(aw_addr_r, `OFF_CLOCK_PRESCALE)) begin
                clock_prescale_r <= w_data_r[`PRESCALE_W-1:0];
            end
            if (word_hit(aw_addr_r, `OFF_INTERRUPT_ENABLE)) begin
                interrupt_enable_r <= w_data_r[`FLAG_W-1:0];
            end
            if (word_hit(aw_addr_r, `OFF_EVENT_MASK)) begin
                event_mask_r <= w_data_r[`FLAG_W-1:0];
            end
        end
    end

    // Write channel: address and data are taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= {`ADDR_W{1'b0}};
            w_data_r <= {`DATA_W{1'b0}};
            w_strb_r <= `WSTRB_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_held_r && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (!w_held_r && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_r) ? `RESP_OKAY
                    : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read mux; the clear register is write-only and reads zero
    always @* begin
        rd_word = {`DATA_W{1'b0}};
        if (word_hit(s_axi_araddr, `OFF_CLOCK_PRESCALE)) begin
            rd_word[`PRESCALE_W-1:0] = clock_prescale_r;
        end else if (word_hit(s_axi_araddr, `OFF_INTERRUPT_ENABLE)) begin
            rd_word[`FLAG_W-1:0] = interrupt_enable_r;
        end else if (word_hit(s_axi_araddr, `OFF_RAW_STATUS)) begin
            rd_word[`FLAG_W-1:0] = raw_flags;
        end else if (word_hit(s_axi_araddr, `OFF_MASKED_STATUS)) begin
            rd_word[`FLAG_W-1:0] = masked_flags;
        end else if (word_hit(s_axi_araddr, `OFF_EVENT_STATUS)) begin
            rd_word[`FLAG_W-1:0] = event_status;
        end else if (word_hit(s_axi_araddr, `OFF_EVENT_MASK)) begin
            rd_word[`FLAG_W-1:0] = event_mask_r;
        end
    end

    // One read at a time; arready drops until the data is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= {`DATA_W{1'b0}};
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY
                    : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

//--- bench/sync_serial_irq_props.sv
/* Concurrent checks on the serial port interrupt block.
   Assumes binding to the top module; sees its ports only. */
`timescale 1ns/1ns
`include "sync_serial_irq_regs.vh"
module sync_serial_irq_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [`DATA_W-1:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire tx_fifo_low,
    input wire rx_fifo_level,
    input wire rx_timeout_hit,
    input wire rx_overrun_hit,
    input wire [`PRESCALE_W-1:0] clock_prescale_r,
    input wire irq_r
);
    wire any_src;
    assign any_src = tx_fifo_low | rx_fifo_level | rx_timeout_hit |
        rx_overrun_hit;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("no read answer");
    a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=>
        !s_axi_awready) else $error("awready stayed high");
    a_w_taken: assert property (s_axi_wvalid && s_axi_wready |=>
        !s_axi_wready) else $error("wready stayed high");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp ==
        `RESP_OKAY || s_axi_bresp == `RESP_SLVERR) else $error("bad bresp");
    a_prescale_on_write: assert property ($changed(clock_prescale_r) |->
        $rose(s_axi_bvalid)) else $error("prescale changed without write");
    // An edge of the interrupt needs a source two cycles back or a write
    a_irq_has_cause: assert property ($rose(irq_r) |-> s_axi_bvalid ||
        $past(s_axi_bvalid) || $past(any_src, 2)) else $error("stray irq");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(irq_r));
endmodule
bind sync_serial_irq_enable sync_serial_irq_props u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tx_fifo_low(tx_fifo_low),
    .rx_fifo_level(rx_fifo_level), .rx_timeout_hit(rx_timeout_hit),
    .rx_overrun_hit(rx_overrun_hit), .clock_prescale_r(clock_prescale_r),
    .irq_r(irq_r));

//--- bench/sync_serial_irq_enable_test.sv
/* Register level test of the serial port interrupt block.
   Assumes an AXI4-Lite slave and condition inputs on the same clock. */
`timescale 1ns/1ns
`include "sync_serial_irq_regs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module sync_serial_irq_enable_test;
    int fails = 0;
    int n_checks = 0;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0;
    reg tx_low = 1'b1, rx_lvl = 1'b0, to_hit = 1'b0, ov_hit = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    wire awready, wready, bvalid, arready, rvalid, irq, event_irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] prescale;
    sync_serial_irq_enable dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_fifo_low(tx_low),
        .rx_fifo_level(rx_lvl), .rx_timeout_hit(to_hit),
        .rx_overrun_hit(ov_hit), .clock_prescale_r(prescale), .irq_r(irq),
        .event_irq_r(event_irq));
    always #2 aclk = ~aclk;
    task final_report;
        if (fails == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Ready is registered, so the negedge value is what the edge sees
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        reg aw_hit, w_hit, b_hit;
        reg [1:0] r;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hit = 1'b0;
        n = 0;
        while (!b_hit && n < 100) begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            r = bresp;
            @(posedge aclk);
            n++;
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!b_hit) fails++;
        `CHK(r, er)
    endtask
    task rd_chk(input [7:0] a, input [31:0] e, input [1:0] er);
        reg ar_hit, r_hit;
        reg [31:0] d;
        reg [1:0] r;
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hit = 1'b0;
        n = 0;
        while (!r_hit && n < 100) begin
            @(negedge aclk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            n++;
            if (ar_hit) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!r_hit) fails++;
        `CHK(d, e)
        `CHK(r, er)
    endtask
    task pulse(input bit t);
        @(posedge aclk);
        if (t) to_hit <= 1'b1;
        else ov_hit <= 1'b1;
        @(posedge aclk);
        to_hit <= 1'b0;
        ov_hit <= 1'b0;
    endtask
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        final_report;
    end
    initial begin
        int i, p;
        reg [3:0] raw, m;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`OFF_RAW_STATUS, 32'h8, `RESP_OKAY);
        rd_chk(`OFF_INTERRUPT_ENABLE, 32'h0, `RESP_OKAY);
        rd_chk(`OFF_MASKED_STATUS, 32'h0, `RESP_OKAY);
        wr(`OFF_CLOCK_PRESCALE, 32'hA5, `RESP_OKAY);
        `CHK(prescale, 8'hA5)
        rd_chk(`OFF_CLOCK_PRESCALE, 32'hA5, `RESP_OKAY);
        // Level sources swap between passes; sticky ones must survive
        for (p = 0; p < 2; p++) begin
            @(posedge aclk);
            tx_low <= p[0];
            rx_lvl <= !p[0];
            if (p == 0) pulse(1'b1);
            if (p == 0) pulse(1'b0);
            raw = p ? 4'hB : 4'h7;
            for (i = 0; i < 4; i++) begin
                m = raw & (4'h1 << i);
                wr(`OFF_INTERRUPT_ENABLE, 32'h1 << i, `RESP_OKAY);
                rd_chk(`OFF_MASKED_STATUS, m, `RESP_OKAY);
                `CHK(irq, raw[i])
            end
            wr(`OFF_INTERRUPT_ENABLE, 32'h0, `RESP_OKAY);
            rd_chk(`OFF_RAW_STATUS, raw, `RESP_OKAY);
            `CHK(irq, 1'b0)
        end
        wr(`OFF_INTERRUPT_CLEAR, 32'h0, `RESP_OKAY);
        rd_chk(`OFF_RAW_STATUS, 32'hB, `RESP_OKAY);
        wr(`OFF_INTERRUPT_CLEAR, 32'h2, `RESP_OKAY);
        rd_chk(`OFF_RAW_STATUS, 32'h9, `RESP_OKAY);
        wr(`OFF_INTERRUPT_CLEAR, 32'h1, `RESP_OKAY);
        rd_chk(`OFF_RAW_STATUS, 32'h8, `RESP_OKAY);
        rd_chk(`OFF_EVENT_STATUS, 32'hF, `RESP_OKAY);
        rd_chk(`OFF_EVENT_STATUS, 32'h0, `RESP_OKAY);
        wr(`OFF_EVENT_MASK, 32'h1, `RESP_OKAY);
        rd_chk(`OFF_EVENT_MASK, 32'h1, `RESP_OKAY);
        pulse(1'b1);
        repeat (4) @(posedge aclk);
        `CHK(event_irq, 1'b0)
        pulse(1'b0);
        repeat (4) @(posedge aclk);
        `CHK(event_irq, 1'b1)
        rd_chk(`OFF_EVENT_STATUS, 32'h3, `RESP_OKAY);
        // The output drops on the edge the read task ends on; let it settle
        @(posedge aclk);
        `CHK(event_irq, 1'b0)
        wr(8'h40, 32'hF, `RESP_SLVERR);
        rd_chk(8'h40, 32'h0, `RESP_SLVERR);
        wr(`OFF_RAW_STATUS, 32'h0, `RESP_OKAY);
        rd_chk(`OFF_RAW_STATUS, 32'hB, `RESP_OKAY);
        final_report;
    end
endmodule
